// >>> core/asp_pkg.sv
// Purpose: shared constants and types of the async serial port
// Assumes: one 125 MHz system clock, byte-wide register port
// Notes:   mode field is {upper_mode, lower_mode}
`default_nettype none
package asp_pkg;
  localparam int unsigned ASP_DATA_W      = 8;
  localparam logic [7:0]  ASP_OFF_PWR_CTRL = 8'h87;
  localparam logic [7:0]  ASP_OFF_SER_CTRL = 8'h98;
  localparam logic [7:0]  ASP_OFF_SER_BUF  = 8'h99;
  localparam logic [7:0]  ASP_OFF_STN_ADDR = 8'ha9;
  localparam logic [7:0]  ASP_OFF_STN_MASK = 8'hb9;
  localparam logic [7:0]  ASP_RST_STN      = 8'h00;
  localparam logic [7:0]  ASP_RST_ZERO     = 8'h00;
  // serial control bit positions
  localparam int unsigned ASP_CB_SHARED   = 7;
  localparam int unsigned ASP_CB_LOWER    = 6;
  localparam int unsigned ASP_CB_MP       = 5;
  localparam int unsigned ASP_CB_RXEN     = 4;
  localparam int unsigned ASP_CB_TX9      = 3;
  localparam int unsigned ASP_CB_RX9      = 2;
  localparam int unsigned ASP_CB_TXDONE   = 1;
  localparam int unsigned ASP_CB_RXDONE   = 0;
  // power control bit positions
  localparam int unsigned ASP_PB_DBL      = 7;
  localparam int unsigned ASP_PB_VIEW     = 6;
  // 16x tick prescaler end counts
  localparam logic [1:0]  ASP_PRE_TMR_DBL = 2'h0;
  localparam logic [1:0]  ASP_PRE_TMR     = 2'h1;
  localparam logic [1:0]  ASP_PRE_OSC_DBL = 2'h1;
  localparam logic [1:0]  ASP_PRE_OSC     = 2'h3;
  // bit slicing and frame indices
  localparam logic [3:0]  ASP_SLICE_LAST  = 4'hf;
  localparam logic [3:0]  ASP_VOTE_A      = 4'h7;
  localparam logic [3:0]  ASP_VOTE_B      = 4'h8;
  localparam logic [3:0]  ASP_VOTE_C      = 4'h9;
  localparam logic [3:0]  ASP_DATA_LAST   = 4'h8;
  localparam logic [3:0]  ASP_NINTH_IDX   = 4'h9;
  localparam logic [3:0]  ASP_LAST_10     = 4'h9;
  localparam logic [3:0]  ASP_LAST_11     = 4'ha;
  typedef enum logic [1:0] {
    ASP_MODE_SYNC  = 2'b00,
    ASP_MODE_TMR10 = 2'b01,
    ASP_MODE_OSC11 = 2'b10,
    ASP_MODE_TMR11 = 2'b11
  } asp_mode_type;
  typedef enum logic {
    ASP_RX_HUNT = 1'b0,
    ASP_RX_RECV = 1'b1
  } asp_rx_state_type;
endpackage : asp_pkg
`default_nettype wire

// >>> core/asp_vote.sv
// Purpose: best-of-three bit decision over three sample slices
// Assumes: i_take marks the first two slices, third is live
// Notes:   result valid in the third slice only
`default_nettype none
module asp_vote (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_take,
  input  wire logic i_line,
  output logic      o_bit
);
  logic [1:0] smp_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      smp_q <= 2'h3;
    end else if (i_take) begin
      smp_q <= {smp_q[0], i_line};
    end
  end
  // majority of two stored samples and the live one
  assign o_bit = (smp_q[1] & smp_q[0]) | (smp_q[1] & i_line) | (smp_q[0] & i_line);
endmodule : asp_vote
`default_nettype wire

// >>> core/asp_addr_match.sv
// Purpose: given and broadcast station address compare
// Assumes: mask zero bits are don't-care for the given address; for broadcast, zero bits of station OR mask are
// Notes:   purely combinational
`default_nettype none
module asp_addr_match (
  input  wire logic [7:0] i_byte,
  input  wire logic [7:0] i_station,
  input  wire logic [7:0] i_mask,
  output logic            o_match
);
  logic [7:0] bcast;
  logic       given_hit;
  logic       bcast_hit;
  assign bcast     = i_station | i_mask;
  assign given_hit = ((i_byte ^ i_station) & i_mask) == 8'h00;
  assign bcast_hit = ((i_byte ^ bcast) & bcast) == 8'h00;
  assign o_match   = given_hit | bcast_hit;
endmodule : asp_addr_match
`default_nettype wire

// >>> core/asp_uart.sv
// Purpose: async serial port, modes 1 to 3, with address recognition
// Assumes: i_timer_ovf is a one-cycle timer overflow pulse
// Notes:   mode 0 (sync) idles both directions
`default_nettype none
module asp_uart (
  input  wire logic                             i_sys_clk,
  input  wire logic                             i_rst,
  input  wire logic [7:0]                       i_addr,
  input  wire logic [asp_pkg::ASP_DATA_W-1:0]   i_wdata,
  input  wire logic                             i_wr,
  input  wire logic                             i_rd,
  input  wire logic                             i_timer_ovf,
  input  wire logic                             i_rxd,
  output logic                                  o_txd,
  output logic [asp_pkg::ASP_DATA_W-1:0]        o_rdata
);
  import asp_pkg::*;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // control and status
  logic             upper_mode_q;
  logic             lower_mode_q;
  logic             multiproc_q;
  logic             rx_enable_q;
  logic             tx_ninth_q;
  logic             rx_ninth_q;
  logic             transmit_done_q;
  logic             receive_done_q;
  logic             frame_err_q;
  logic             baud_dbl_q;
  logic             err_view_q;
  logic [7:0]       station_q;
  logic [7:0]       mask_q;
  logic [7:0]       rx_buf_q;
  asp_mode_type     mode;
  // baud generation
  logic [1:0]       pre_q;
  logic [1:0]       pre_end;
  logic             pre_src;
  logic             tick16;
  // transmitter
  logic [3:0]       tx_div_q;
  logic [3:0]       tx_cnt_q;
  logic [10:0]      tx_shift_q;
  logic             tx_busy_q;
  logic             tx_roll;
  logic             tx_last;
  logic [3:0]       frame_last;
  // receiver
  asp_rx_state_type rx_state_q;
  logic [3:0]       rx_div_q;
  logic [3:0]       rx_bit_q;
  logic [7:0]       rx_data_q;
  logic             rx_nine_q;
  logic             line_q;
  logic             rx_edge;
  logic             rx_take;
  logic             rx_decide;
  logic             voted;
  logic             rx_abort;
  logic             rx_finish;
  logic             addr_hit;
  logic             accept;
  logic             ninth_eff;
  // register port decode
  logic             wr_ctrl;
  logic             wr_buf;
  logic             wr_pwr;

  assign mode    = asp_mode_type'({upper_mode_q, lower_mode_q});
  assign wr_ctrl = i_wr && (i_addr == ASP_OFF_SER_CTRL);
  assign wr_buf  = i_wr && (i_addr == ASP_OFF_SER_BUF);
  assign wr_pwr  = i_wr && (i_addr == ASP_OFF_PWR_CTRL);

  // 16x sample tick: timer overflow /1 or /2, or clock /2 or /4
  always_comb begin
    unique case (mode)
      ASP_MODE_OSC11: begin
        pre_src = 1'b1;
        pre_end = baud_dbl_q ? ASP_PRE_OSC_DBL : ASP_PRE_OSC;
      end
      ASP_MODE_TMR10, ASP_MODE_TMR11: begin
        pre_src = i_timer_ovf;
        pre_end = baud_dbl_q ? ASP_PRE_TMR_DBL : ASP_PRE_TMR;
      end
      ASP_MODE_SYNC: begin
        pre_src = 1'b0;
        pre_end = ASP_PRE_TMR_DBL;
      end
    endcase
  end

  assign tick16 = pre_src && (pre_q == pre_end);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || mode == ASP_MODE_SYNC) begin
      pre_q <= 2'h0;
    end else if (pre_src) begin
      pre_q <= (pre_q == pre_end) ? 2'h0 : pre_q + 2'h1;
    end
  end

  // transmit divider: a rollover every sixteen ticks
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_div_q <= 4'h0;
    end else if (tick16) begin
      tx_div_q <= tx_div_q + 4'h1;
    end
  end

  assign tx_roll    = tick16 && (tx_div_q == ASP_SLICE_LAST);
  assign frame_last = (mode == ASP_MODE_TMR10) ? ASP_LAST_10 : ASP_LAST_11;
  assign tx_last    = tx_roll && tx_busy_q && (tx_cnt_q == frame_last);

  // transmitter shift path; the write only arms it
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_shift_q <= 11'h7ff;
      tx_cnt_q   <= 4'h0;
      tx_busy_q  <= 1'b0;
      o_txd      <= 1'b1;
    end else if (wr_buf && mode != ASP_MODE_SYNC) begin
      tx_cnt_q  <= 4'h0;
      tx_busy_q <= 1'b1;
      if (mode == ASP_MODE_TMR10) begin
        tx_shift_q <= {2'b11, i_wdata, 1'b0};
      end else begin
        tx_shift_q <= {1'b1, tx_ninth_q, i_wdata, 1'b0};
      end
    end else if (tx_roll && tx_busy_q) begin
      o_txd      <= tx_shift_q[0];
      tx_shift_q <= {1'b1, tx_shift_q[10:1]};
      tx_cnt_q   <= tx_cnt_q + 4'h1;
      if (tx_cnt_q == frame_last) begin
        tx_busy_q <= 1'b0;
      end
    end
  end

  // receiver hunting and bit slicing
  assign rx_edge   = (rx_state_q == ASP_RX_HUNT) && rx_enable_q && (mode != ASP_MODE_SYNC)
                     && tick16 && line_q && !i_rxd;
  assign rx_take   = (rx_state_q == ASP_RX_RECV) && tick16
                     && (rx_div_q == ASP_VOTE_A || rx_div_q == ASP_VOTE_B);
  assign rx_decide = (rx_state_q == ASP_RX_RECV) && tick16 && (rx_div_q == ASP_VOTE_C);
  assign rx_abort  = rx_decide && (rx_bit_q == 4'h0) && voted;
  assign rx_finish = rx_decide && (rx_bit_q == frame_last);
  assign ninth_eff = (mode == ASP_MODE_TMR10) ? voted : rx_nine_q;
  assign accept    = rx_finish && !receive_done_q
                     && (!multiproc_q || ((mode == ASP_MODE_TMR10) ? voted
                         : (rx_nine_q && addr_hit)));

  asp_vote u_vote (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_take    (rx_take),
    .i_line    (i_rxd),
    .o_bit     (voted)
  );

  asp_addr_match u_match (
    .i_byte    (rx_data_q),
    .i_station (station_q),
    .i_mask    (mask_q),
    .o_match   (addr_hit)
  );

  // line history for the falling-edge search
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      line_q <= 1'b1;
    end else if (tick16) begin
      line_q <= i_rxd;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rx_state_q <= ASP_RX_HUNT;
      rx_div_q   <= 4'h0;
      rx_bit_q   <= 4'h0;
      rx_data_q  <= ASP_RST_ZERO;
      rx_nine_q  <= 1'b0;
    end else if (rx_edge) begin
      rx_state_q <= ASP_RX_RECV;
      rx_div_q   <= 4'h0;
      rx_bit_q   <= 4'h0;
    end else if (rx_state_q == ASP_RX_RECV && tick16) begin
      rx_div_q <= rx_div_q + 4'h1;
      if (rx_abort || rx_finish) begin
        rx_state_q <= ASP_RX_HUNT;
      end else if (rx_decide) begin
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q != 4'h0 && rx_bit_q <= ASP_DATA_LAST) begin
          rx_data_q <= {voted, rx_data_q[7:1]};
        end else if (rx_bit_q == ASP_NINTH_IDX) begin
          rx_nine_q <= voted;
        end
      end
    end
  end

  // receive buffer only changes on an accepted frame
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rx_buf_q <= ASP_RST_ZERO;
    end else if (accept) begin
      rx_buf_q <= rx_data_q;
    end
  end

  // serial control; hardware set wins over a software write
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      upper_mode_q    <= 1'b0;
      lower_mode_q    <= 1'b0;
      multiproc_q     <= 1'b0;
      rx_enable_q     <= 1'b0;
      tx_ninth_q      <= 1'b0;
      rx_ninth_q      <= 1'b0;
      transmit_done_q <= 1'b0;
      receive_done_q  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        if (!err_view_q) begin
          upper_mode_q <= i_wdata[ASP_CB_SHARED];
        end
        lower_mode_q    <= i_wdata[ASP_CB_LOWER];
        multiproc_q     <= i_wdata[ASP_CB_MP];
        rx_enable_q     <= i_wdata[ASP_CB_RXEN];
        tx_ninth_q      <= i_wdata[ASP_CB_TX9];
        rx_ninth_q      <= i_wdata[ASP_CB_RX9];
        transmit_done_q <= i_wdata[ASP_CB_TXDONE];
        receive_done_q  <= i_wdata[ASP_CB_RXDONE];
      end
      if (tx_last) begin
        transmit_done_q <= 1'b1;
      end
      if (accept) begin
        rx_ninth_q     <= ninth_eff;
        receive_done_q <= 1'b1;
      end
    end
  end

  // frame error: set by hardware, cleared by writing zero in view
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      frame_err_q <= 1'b0;
    end else if (rx_finish && !voted) begin
      frame_err_q <= 1'b1;
    end else if (wr_ctrl && err_view_q && !i_wdata[ASP_CB_SHARED]) begin
      frame_err_q <= 1'b0;
    end
  end

  // power control, station address and mask
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      baud_dbl_q <= 1'b0;
      err_view_q <= 1'b0;
      station_q  <= ASP_RST_STN;
      mask_q     <= ASP_RST_STN;
    end else begin
      if (wr_pwr) begin
        baud_dbl_q <= i_wdata[ASP_PB_DBL];
        err_view_q <= i_wdata[ASP_PB_VIEW];
      end
      if (i_wr && i_addr == ASP_OFF_STN_ADDR) begin
        station_q <= i_wdata;
      end
      if (i_wr && i_addr == ASP_OFF_STN_MASK) begin
        mask_q <= i_wdata;
      end
    end
  end

  // read data stand for one cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_rd) begin
      o_rdata <= ASP_RST_ZERO;
    end else begin
      unique case (i_addr)
        ASP_OFF_SER_CTRL: o_rdata <= {err_view_q ? frame_err_q : upper_mode_q,
                                      lower_mode_q, multiproc_q, rx_enable_q, tx_ninth_q,
                                      rx_ninth_q, transmit_done_q, receive_done_q};
        ASP_OFF_SER_BUF:  o_rdata <= rx_buf_q;
        ASP_OFF_PWR_CTRL: o_rdata <= {baud_dbl_q, err_view_q, 6'h00};
        ASP_OFF_STN_ADDR: o_rdata <= station_q;
        ASP_OFF_STN_MASK: o_rdata <= mask_q;
        default:          o_rdata <= ASP_RST_ZERO;
      endcase
    end
  end

  // checks
  sequence osc_fast_gap_s;
    !tick16 ##1 tick16;
  endsequence

  sequence tx_arm_s;
    wr_buf && (mode != ASP_MODE_SYNC);
  endsequence

  tx_start_a: assert property (tx_roll && tx_busy_q && tx_cnt_q == 4'h0 |=> !o_txd)
    else $error("start bit not driven at first rollover");

  tx_idle_a: assert property (tx_arm_s ##1 (!tx_roll)[*1] |=> o_txd == $past(o_txd))
    else $error("line changed before rollover");

  tx_done_a: assert property (tx_last |=> transmit_done_q && o_txd)
    else $error("done flag or stop bit missing at last rollover");

  rx_gate_a: assert property (!rx_enable_q && rx_state_q == ASP_RX_HUNT |=>
                              rx_state_q == ASP_RX_HUNT)
    else $error("reception started while disabled");

  edge_align_a: assert property (rx_edge |=> rx_div_q == 4'h0 && rx_state_q == ASP_RX_RECV)
    else $error("divider not realigned on edge");

  start_abort_a: assert property (rx_abort |=> rx_state_q == ASP_RX_HUNT && $stable(rx_buf_q))
    else $error("bad start bit not abandoned");

  osc_rate_a: assert property (mode == ASP_MODE_OSC11 && baud_dbl_q && tick16 &&
                               !wr_pwr && !wr_ctrl |=> osc_fast_gap_s)
    else $error("oscillator tick spacing wrong");

  accept_load_a: assert property (accept |=> receive_done_q && rx_buf_q == $past(rx_data_q)
                                  && rx_ninth_q == $past(ninth_eff))
    else $error("accepted frame not loaded");

  reject_keep_a: assert property (rx_finish && receive_done_q |=> $stable(rx_buf_q)
                                  && receive_done_q)
    else $error("rejected frame corrupted buffer");

  err_set_a: assert property (rx_finish && !voted |=> frame_err_q)
    else $error("frame error not raised");

  err_sticky_a: assert property (frame_err_q && !(wr_ctrl && err_view_q) |=> frame_err_q)
    else $error("frame error cleared without software");

  mp_filter_a: assert property (rx_finish && multiproc_q && mode != ASP_MODE_TMR10 &&
                                !(rx_nine_q && addr_hit) && !wr_ctrl |=>
                                receive_done_q == $past(receive_done_q))
    else $error("unmatched frame raised receive flag");
endmodule : asp_uart
`default_nettype wire

// >>> testbench/asp_far_end.sv
// Purpose: far-end serial station that faces the port's pins
// Assumes: bit time of BIT_CLKS system clocks, idle line high
// Notes:   tasks are called from the bench, one at a time
`default_nettype none
module asp_far_end #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic i_sys_clk,
  input  wire logic i_txd,
  output var  logic o_rxd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_rxd = 1'b1;
  end

  // sends start, data lsb first, optional ninth, then a stop of stop_clks
  task automatic send_frame(input logic [7:0] data, input logic nine_en, input logic ninth,
                            input logic stop, input int stop_clks);
    logic [9:0] bits;
    int         n;
    bits = nine_en ? {ninth, data, 1'b0} : {1'b0, data, 1'b0};
    n = nine_en ? 10 : 9;
    for (int i = 0; i < n; i++) begin
      o_rxd <= bits[i];
      repeat (BIT_CLKS) @(posedge i_sys_clk);
    end
    o_rxd <= stop;
    repeat (stop_clks) @(posedge i_sys_clk);
    o_rxd <= 1'b1;
    @(posedge i_sys_clk);
  endtask : send_frame

  // short low pulse on the line, too short to be a start bit
  task automatic glitch(input int clks);
    o_rxd <= 1'b0;
    repeat (clks) @(posedge i_sys_clk);
    o_rxd <= 1'b1;
    @(posedge i_sys_clk);
  endtask : glitch

  // waits for a start edge, then samples each bit in its middle
  task automatic recv_frame(input logic nine_en, output logic [10:0] bits, output int waited);
    int n;
    waited = 0;
    bits = '0;
    n = nine_en ? 11 : 10;
    while (i_txd !== 1'b0 && waited < 4000) begin
      @(posedge i_sys_clk);
      waited++;
    end
    repeat (BIT_CLKS / 2) @(posedge i_sys_clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = i_txd;
      if (i < n - 1) begin
        repeat (BIT_CLKS) @(posedge i_sys_clk);
      end
    end
  endtask : recv_frame
endmodule : asp_far_end
`default_nettype wire

// >>> testbench/tb_async_serial_port_addr_match.sv
// Purpose: self-checking bench for the async serial port
// Assumes: timer overflow every 2 clocks, doubling on, so one bit is 32 clocks
// Notes:   each scenario starts from a fresh reset
`default_nettype none
module tb_async_serial_port_addr_match;
  timeunit 1ns;
  timeprecision 1ps;
  import asp_pkg::*;

  logic       sys_clk;
  logic       rst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       ovf;
  logic       rxd;
  logic       txd;
  logic [7:0] rdata;
  int         err_total;
  int         num_checks;

  asp_uart dut (
    .i_sys_clk   (sys_clk),
    .i_rst       (rst),
    .i_addr      (addr),
    .i_wdata     (wdata),
    .i_wr        (wr),
    .i_rd        (rd),
    .i_timer_ovf (ovf),
    .i_rxd       (rxd),
    .o_txd       (txd),
    .o_rdata     (rdata)
  );

  asp_far_end #(.BIT_CLKS(32)) far (
    .i_sys_clk (sys_clk),
    .i_txd     (txd),
    .o_rxd     (rxd)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // timer overflow pulse every second clock, from one process only
  initial begin
    ovf = 1'b0;
    forever @(posedge sys_clk) ovf <= ~ovf;
  end

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic do_reset;
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
  endtask : do_reset

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge sys_clk);
  endtask : reg_rd

  task automatic t_regs;
    logic [7:0] v;
    do_reset;
    reg_rd(ASP_OFF_STN_ADDR, v); chk8(v, 8'h00);
    reg_rd(ASP_OFF_STN_MASK, v); chk8(v, 8'h00);
    reg_wr(ASP_OFF_STN_ADDR, 8'h5a);
    reg_wr(ASP_OFF_STN_MASK, 8'hc3);
    reg_rd(ASP_OFF_STN_ADDR, v); chk8(v, 8'h5a);
    reg_rd(ASP_OFF_STN_MASK, v); chk8(v, 8'hc3);
    reg_rd(8'h10, v); chk8(v, 8'h00);
    reg_rd(ASP_OFF_SER_CTRL, v); chk8(v, 8'h00);
  endtask : t_regs

  // transmit one frame in the given mode and capture it at the far end
  task automatic t_tx(input logic [7:0] mode, input logic [7:0] d, input logic n9);
    logic [10:0] b;
    logic [7:0]  v;
    logic [7:0]  ctl;
    int          w;
    ctl = mode | {4'h0, n9, 3'h0};
    do_reset;
    reg_wr(ASP_OFF_PWR_CTRL, 8'h80);
    reg_wr(ASP_OFF_SER_CTRL, ctl);
    reg_wr(ASP_OFF_SER_BUF, d);
    far.recv_frame(mode[7], b, w);
    chk8({7'h0, w <= 34}, 8'h01);
    if (mode[7]) begin
      chk16({5'h0, b}, {5'h0, 1'b1, n9, d, 1'b0});
    end else begin
      chk16({5'h0, b}, {5'h0, 1'b0, 1'b1, d, 1'b0});
    end
    reg_rd(ASP_OFF_SER_CTRL, v); chk8(v, ctl | 8'h02);
    chk8({7'h0, txd}, 8'h01);
  endtask : t_tx

  // slow rates: one bit is 64 clocks, timed on the start bit
  task automatic t_slow(input logic [7:0] ctl);
    int c;
    do_reset;
    reg_wr(ASP_OFF_SER_CTRL, ctl);
    reg_wr(ASP_OFF_SER_BUF, 8'hff);
    c = 0;
    while (txd !== 1'b0 && c < 200) begin
      @(posedge sys_clk);
      c++;
    end
    c = 0;
    while (txd === 1'b0 && c < 200) begin
      @(posedge sys_clk);
      c++;
    end
    chk8(c[7:0], 8'h40);
  endtask : t_slow

  task automatic t_rx;
    logic [7:0] v;
    do_reset;
    reg_wr(ASP_OFF_PWR_CTRL, 8'h80);
    reg_wr(ASP_OFF_SER_CTRL, 8'h40);
    far.send_frame(8'h3c, 1'b0, 1'b0, 1'b1, 32);
    reg_rd(ASP_OFF_SER_CTRL, v); chk8(v, 8'h40);
    reg_wr(ASP_OFF_SER_CTRL, 8'h50);
    far.glitch(4);
    repeat (40) @(posedge sys_clk);
    far.send_frame(8'hc3, 1'b0, 1'b0, 1'b1, 32);
    reg_rd(ASP_OFF_SER_BUF, v); chk8(v, 8'hc3);
    reg_rd(ASP_OFF_SER_CTRL, v); chk8(v, 8'h55);
    far.send_frame(8'h18, 1'b0, 1'b0, 1'b1, 32);
    reg_rd(ASP_OFF_SER_BUF, v); chk8(v, 8'hc3);
  endtask : t_rx

  task automatic t_fe;
    logic [7:0] v;
    do_reset;
    reg_wr(ASP_OFF_PWR_CTRL, 8'h80);
    reg_wr(ASP_OFF_SER_CTRL, 8'h90);
    reg_wr(ASP_OFF_PWR_CTRL, 8'hc0);
    reg_rd(ASP_OFF_SER_CTRL, v); chk8(v, 8'h10);
    far.send_frame(8'h11, 1'b1, 1'b0, 1'b0, 32);
    reg_rd(ASP_OFF_SER_CTRL, v); chk8(v, 8'h91);
    reg_wr(ASP_OFF_SER_CTRL, 8'h90);
    far.send_frame(8'h22, 1'b1, 1'b1, 1'b1, 32);
    reg_rd(ASP_OFF_SER_CTRL, v); chk8(v, 8'h95);
    reg_wr(ASP_OFF_SER_CTRL, 8'h14);
    reg_rd(ASP_OFF_SER_CTRL, v); chk8(v, 8'h14);
    reg_wr(ASP_OFF_PWR_CTRL, 8'h80);
    reg_rd(ASP_OFF_SER_CTRL, v); chk8(v, 8'h94);
  endtask : t_fe

  // one frame with a short stop; rejected frames run straight into the next
  task automatic mp_step(input logic [7:0] d, input logic n9, input logic acc,
                         input logic [7:0] ctl);
    logic [7:0] v;
    far.send_frame(d, 1'b1, n9, 1'b1, 24);
    if (acc) begin
      repeat (4) @(posedge sys_clk);
      reg_rd(ASP_OFF_SER_BUF, v); chk8(v, d);
      reg_rd(ASP_OFF_SER_CTRL, v); chk8(v, ctl | {5'h0, n9, 2'b01});
      reg_wr(ASP_OFF_SER_CTRL, ctl);
    end
  endtask : mp_step

  task automatic t_mp;
    do_reset;
    reg_wr(ASP_OFF_PWR_CTRL, 8'h80);
    reg_wr(ASP_OFF_SER_CTRL, 8'hf0);
    mp_step(8'h5a, 1'b1, 1'b1, 8'hf0);
    reg_wr(ASP_OFF_STN_ADDR, 8'ha4);
    reg_wr(ASP_OFF_STN_MASK, 8'hfa);
    mp_step(8'ha2, 1'b1, 1'b0, 8'hf0);
    mp_step(8'h55, 1'b0, 1'b0, 8'hf0);
    mp_step(8'ha1, 1'b1, 1'b1, 8'hf0);
    mp_step(8'h7f, 1'b1, 1'b0, 8'hf0);
    mp_step(8'hff, 1'b1, 1'b1, 8'hf0);
    reg_wr(ASP_OFF_SER_CTRL, 8'hd0);
    mp_step(8'h33, 1'b0, 1'b1, 8'hd0);
  endtask : t_mp

  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    tally_and_finish;
  end

  initial begin
    err_total  = 0;
    num_checks = 0;
    rst   = 1'b1;
    addr  = 8'h00;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
    do_reset;
    t_regs;
    t_tx(8'h40, 8'ha5, 1'b0);
    t_tx(8'h80, 8'h3c, 1'b1);
    t_tx(8'hc0, 8'h96, 1'b0);
    t_slow(8'h80);
    t_slow(8'h40);
    t_rx;
    t_fe;
    t_mp;
    tally_and_finish;
  end
endmodule : tb_async_serial_port_addr_match
`default_nettype wire
